// File: rtl/cfs_top.sv
// Register slave, flags and interrupts of the sixteen message FIFOs
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "cfs_consts.svh"
module cfs_top #(
  parameter int DEPTH = 32,
  parameter int MSG_BYTES = 16,
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`CFS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CFS_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`CFS_NUM_FIFOS-1:0] engAdv,
  output logic irq
);
  localparam int NF = `CFS_NUM_FIFOS;
  localparam int IW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // Bus slave state
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic awHave_q;
  logic awHave_d;
  logic wHave_q;
  logic wHave_d;
  logic [`CFS_ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Software visible state
  cfs_pkg::cfs_opmode_t opmode_q;
  logic [NF-1:0] dir_q;
  logic [NF-1:0] dir_d;
  logic [NF-1:0] intStat_q;
  logic [NF-1:0] intStat_d;
  logic [NF-1:0] intMask_q;
  logic irq_q;

  // Per FIFO status
  logic [IW-1:0] userIdxA [NF];
  logic [IW-1:0] engIdxA [NF];
  logic [CW-1:0] countA [NF];
  logic [31:0] userAddrA [NF];
  logic [NF-1:0] ovflRaw;
  logic [NF-1:0] ovflEvt;
  logic [NF-1:0] engDone;
  logic [NF-1:0] txHalfV;
  logic [NF-1:0] txEmptyV;
  logic [NF-1:0] rxOvflV;
  logic [NF-1:0] rxFullV;
  logic [NF-1:0] rxHalfV;
  logic [NF-1:0] rxNeV;
  logic [NF-1:0] userAdv;
  logic [NF-1:0] ovflClr;

  // Address decode
  function automatic cfs_pkg::cfs_sel_t decode(
    input logic [`CFS_ADDR_W-1:0] a);
    decode = cfs_pkg::SEL_NONE;
    if (a == `CFS_OFF_CTRL)
      decode = cfs_pkg::SEL_CTRL;
    else if (a == `CFS_OFF_STAT)
      decode = cfs_pkg::SEL_STAT;
    else if (a == `CFS_OFF_MASK)
      decode = cfs_pkg::SEL_MASK;
    else if (a == `CFS_OFF_ADV)
      decode = cfs_pkg::SEL_ADV;
    else if (a[11:8] != `CFS_FIFO_PAGE || a[1:0] != 2'h0)
      decode = cfs_pkg::SEL_NONE;
    else if (a[3:2] == `CFS_FLD_FLAG)
      decode = cfs_pkg::SEL_FLAG;
    else if (a[3:2] == `CFS_FLD_UA)
      decode = cfs_pkg::SEL_UA;
    else if (a[3:2] == `CFS_FLD_CI)
      decode = cfs_pkg::SEL_CI;
    else
      decode = cfs_pkg::SEL_FCTL;
  endfunction : decode

  // Write path
  wire awTake = s_axi_awvalid && awready_q;
  wire wTake = s_axi_wvalid && wready_q;
  wire doWr = awHave_q && wHave_q && !bvalid_q;
  wire cfs_pkg::cfs_sel_t wrSel = decode(awAddr_q);
  wire [3:0] wrFifo = awAddr_q[7:4];
  wire [31:0] wrMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                        {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire [31:0] wrData = wData_q & wrMask;
  wire wrCtrl = doWr && wrSel == cfs_pkg::SEL_CTRL && wStrb_q[2];
  wire wrStat = doWr && wrSel == cfs_pkg::SEL_STAT;
  wire wrMaskReg = doWr && wrSel == cfs_pkg::SEL_MASK;
  wire wrAdv = doWr && wrSel == cfs_pkg::SEL_ADV;
  wire wrFlag = doWr && wrSel == cfs_pkg::SEL_FLAG;
  wire wrFctl = doWr && wrSel == cfs_pkg::SEL_FCTL && wStrb_q[0];
  wire cfgMode = (opmode_q == `CFS_OPMODE_CFG);
  wire [NF-1:0] wrFifoDec = NF'(1) << wrFifo;

  assign awHave_d = (awHave_q && !doWr) || awTake;
  assign wHave_d = (wHave_q && !doWr) || wTake;
  assign bvalid_d = (bvalid_q && !s_axi_bready) || doWr;
  assign awready_d = !awHave_d && !bvalid_d;
  assign wready_d = !wHave_d && !bvalid_d;
  assign userAdv = wrAdv ? wrData[NF-1:0] : '0;
  assign ovflClr = (wrFlag && wrData[`CFS_BIT_RXOVFL]) ? wrFifoDec : '0;
  // Direction changes only in configuration mode
  assign dir_d = (wrFctl && cfgMode) ?
                 ((dir_q & ~wrFifoDec) |
                  (wrData[`CFS_BIT_DIR] ? wrFifoDec : '0)) : dir_q;
  // Sticky events, set wins over write-one-to-clear
  assign intStat_d = (ovflEvt | engDone) |
                     (intStat_q & ~(wrStat ? wrData[NF-1:0] : '0));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `CFS_RESP_OKAY;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awAddr_q <= awTake ? s_axi_awaddr : awAddr_q;
      wData_q <= wTake ? s_axi_wdata : wData_q;
      wStrb_q <= wTake ? s_axi_wstrb : wStrb_q;
      bvalid_q <= bvalid_d;
      bresp_q <= !doWr ? bresp_q :
                 (wrSel == cfs_pkg::SEL_NONE) ? `CFS_RESP_SLVERR :
                 `CFS_RESP_OKAY;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      opmode_q <= `CFS_OPMODE_RST;
      dir_q <= '0;
      intStat_q <= '0;
      intMask_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      opmode_q <= wrCtrl ? wrData[`CFS_OPMODE_HI:`CFS_OPMODE_LO] : opmode_q;
      dir_q <= dir_d;
      intStat_q <= intStat_d;
      intMask_q <= wrMaskReg ? wrData[NF-1:0] : intMask_q;
      irq_q <= |(intStat_q & intMask_q);
    end
  end

  // One pointer block per FIFO
  genvar g;
  generate
    for (g = 0; g < NF; g++)
    begin : gFifo
      cfs_fifo_ptr #(
        .DEPTH(DEPTH),
        .IW(IW),
        .CW(CW)
      ) uPtr (
        .clk(clk),
        .rst_n(rst_n),
        .clear(cfgMode),
        .isTx(dir_q[g]),
        .userAdv(userAdv[g]),
        .engAdv(engAdv[g]),
        .ovflClr(ovflClr[g]),
        .userIdx(userIdxA[g]),
        .engIdx(engIdxA[g]),
        .count(countA[g]),
        .overflow(ovflRaw[g]),
        .ovflEvent(ovflEvt[g]),
        .engDone(engDone[g])
      );
      // Head for transmit, tail for receive
      assign userAddrA[g] = BASE_ADDR +
        32'((g * DEPTH + int'(userIdxA[g])) * MSG_BYTES);
      assign txHalfV[g] = dir_q[g] && countA[g] <= HALF_CNT;
      assign txEmptyV[g] = dir_q[g] && countA[g] == '0;
      assign rxOvflV[g] = !dir_q[g] && ovflRaw[g];
      assign rxFullV[g] = !dir_q[g] && countA[g] == FULL_CNT;
      assign rxHalfV[g] = !dir_q[g] && countA[g] >= HALF_CNT;
      assign rxNeV[g] = !dir_q[g] && countA[g] != '0;
    end
  endgenerate

  // Read path
  wire arTake = s_axi_arvalid && arready_q;
  wire cfs_pkg::cfs_sel_t rdSel = decode(s_axi_araddr);
  wire [3:0] rdFifo = s_axi_araddr[7:4];
  wire [31:0] flagWord = {22'h0, txHalfV[rdFifo], txEmptyV[rdFifo], 4'h0,
                          rxOvflV[rdFifo], rxFullV[rdFifo], rxHalfV[rdFifo],
                          rxNeV[rdFifo]};
  wire [31:0] uaWord = {userAddrA[rdFifo][31:`CFS_UA_ZERO_W],
                        `CFS_UA_ZERO_W'(0)};
  // Engine side slot, upper bits zero
  wire [31:0] ciWord = 32'(engIdxA[rdFifo]);
  wire [31:0] fctlWord = 32'(dir_q[rdFifo]) << `CFS_BIT_DIR;
  wire [31:0] ctrlWord = 32'(opmode_q) << `CFS_OPMODE_LO;
  wire [31:0] rdWord =
    (rdSel == cfs_pkg::SEL_CTRL) ? ctrlWord :
    (rdSel == cfs_pkg::SEL_STAT) ? 32'(intStat_q) :
    (rdSel == cfs_pkg::SEL_MASK) ? 32'(intMask_q) :
    (rdSel == cfs_pkg::SEL_FLAG) ? flagWord :
    (rdSel == cfs_pkg::SEL_UA) ? uaWord :
    (rdSel == cfs_pkg::SEL_CI) ? ciWord :
    (rdSel == cfs_pkg::SEL_FCTL) ? fctlWord : 32'h0000_0000;

  assign rvalid_d = (rvalid_q && !s_axi_rready) || arTake;
  assign arready_d = !rvalid_d;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `CFS_RESP_OKAY;
    end
    else
    begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= arTake ? rdWord : rdata_q;
      rresp_q <= !arTake ? rresp_q :
                 (rdSel == cfs_pkg::SEL_NONE) ? `CFS_RESP_SLVERR :
                 `CFS_RESP_OKAY;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = irq_q;

  // Checks
  logic rdCi_q;
  logic rdUa_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdCi_q <= 1'b0;
      rdUa_q <= 1'b0;
    end
    else if (arTake)
    begin
      rdCi_q <= (rdSel == cfs_pkg::SEL_CI);
      rdUa_q <= (rdSel == cfs_pkg::SEL_UA);
    end
  end

  dir_gating_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((txHalfV | txEmptyV) & ~dir_q) == '0 &&
    ((rxOvflV | rxFullV | rxHalfV | rxNeV) & dir_q) == '0)
    else $error("Flag of the other direction is set");

  tx_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
    dir_q[1] && countA[1] == '0 |-> txEmptyV[1] && txHalfV[1])
    else $error("Empty transmit FIFO does not show empty");

  tx_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    dir_q[1] && countA[1] == HALF_CNT + 1'b1 |-> !txHalfV[1])
    else $error("Transmit half empty set above half");

  rx_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dir_q[0] && countA[0] == FULL_CNT |->
    rxFullV[0] && rxHalfV[0] && rxNeV[0])
    else $error("Full receive FIFO flags wrong");

  rx_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dir_q[0] && countA[0] == HALF_CNT - 1'b1 |-> !rxHalfV[0])
    else $error("Receive half full set below half");

  ovfl_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dir_q[0] && countA[0] == FULL_CNT && engAdv[0] && !cfgMode && !userAdv[0]
    |=> rxOvflV[0] && $stable(countA[0]))
    else $error("Overflow not flagged or full FIFO changed");

  idx_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    engDone[0] && engIdxA[0] == IW'(DEPTH - 1) |=> engIdxA[0] == '0)
    else $error("Engine index does not wrap");

  cfg_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfgMode |=> countA[0] == '0 && engIdxA[0] == '0 && userIdxA[0] == '0)
    else $error("Configuration mode did not clear pointers");

  ci_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && rdCi_q |-> s_axi_rdata[31:`CFS_CI_W] == '0)
    else $error("Message index upper bits not zero");

  ua_align_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && rdUa_q |-> s_axi_rdata[1:0] == 2'h0)
    else $error("User address not aligned");

  irq_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 irq == $past(|(intStat_q & intMask_q)))
    else $error("Interrupt output does not follow masked status");

  wr_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
    awTake && wTake |-> ##[1:2] s_axi_bvalid)
    else $error("Write response late");

  ovfl_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    ovflEvt[0] ##1 rxOvflV[0]);
  tx_drain_c: cover property (@(posedge clk) disable iff (!rst_n)
    dir_q[1] && !txEmptyV[1] ##[1:40] txEmptyV[1]);
  rd_ci_c: cover property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rready && rdCi_q);
  irq_c: cover property (@(posedge clk) disable iff (!rst_n)
    !irq ##1 irq);
endmodule : cfs_top

// File: rtl/cfs_consts.svh
// Constants for the CAN FIFO status and pointer block
//
// Overview of operation
// - Sixteen FIFOs, each with flag, address and index registers.
// - Transmit FIFO: bit 9 is one while at most half full.
// - Transmit FIFO: bit 8 is one while nothing is queued.
// - Flags of the other direction always read zero.
// - Receive FIFO: bit 3 set when a message arrives while full.
// - Receive FIFO: bit 2 is one while every slot is occupied.
// - Receive FIFO: bit 1 is one while at least half full.
// - Receive FIFO: bit 0 is one while any message is held.
// - Level flags are read-only and follow the fill count directly.
// - Transmit FIFO: user address is the head, next slot to write.
// - Receive FIFO: user address is the tail, next slot to read.
// - The two lowest user address bits always read zero.
// - Transmit FIFO: message index is the next slot to transmit.
// - Receive FIFO: message index is the slot for the next reception.
// - Index bits 31 to 5 read zero; index resets to zero.
// - Direction bit 7: one is transmit, zero is receive.
// - Configuration mode means operating mode field equals binary 100.
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH

`define CFS_NUM_FIFOS 16
`define CFS_ADDR_W 12

`define CFS_OFF_CTRL 12'h000
`define CFS_OFF_STAT 12'h004
`define CFS_OFF_MASK 12'h008
`define CFS_OFF_ADV 12'h00c
`define CFS_FIFO_PAGE 4'h1
`define CFS_FLD_FLAG 2'h0
`define CFS_FLD_UA 2'h1
`define CFS_FLD_CI 2'h2
`define CFS_FLD_FCTL 2'h3

`define CFS_BIT_TXHALF 9
`define CFS_BIT_TXEMPTY 8
`define CFS_BIT_RXOVFL 3
`define CFS_BIT_RXFULL 2
`define CFS_BIT_RXHALF 1
`define CFS_BIT_RXNE 0
`define CFS_BIT_DIR 7
`define CFS_OPMODE_HI 23
`define CFS_OPMODE_LO 21

`define CFS_OPMODE_CFG 3'h4
`define CFS_OPMODE_RST 3'h4
`define CFS_CI_W 5
`define CFS_UA_ZERO_W 2

`define CFS_RESP_OKAY 2'h0
`define CFS_RESP_SLVERR 2'h2

`endif

// File: rtl/cfs_pkg.sv
// Types for the CAN FIFO status and pointer block
package cfs_pkg;
  typedef logic [31:0] cfs_word_t;
  typedef logic [2:0] cfs_opmode_t;
  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_STAT,
    SEL_MASK,
    SEL_ADV,
    SEL_FLAG,
    SEL_UA,
    SEL_CI,
    SEL_FCTL
  } cfs_sel_t;
endpackage : cfs_pkg

// File: rtl/cfs_fifo_ptr.sv
// Fill count, pointers and overflow of one message FIFO
`timescale 1ns/100ps
module cfs_fifo_ptr #(
  parameter int DEPTH = 32,
  parameter int IW = $clog2(DEPTH),
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic isTx,
  input wire logic userAdv,
  input wire logic engAdv,
  input wire logic ovflClr,
  output logic [IW-1:0] userIdx,
  output logic [IW-1:0] engIdx,
  output logic [CW-1:0] count,
  output logic overflow,
  output logic ovflEvent,
  output logic engDone
);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);

  logic [IW-1:0] userIdx_q;
  logic [IW-1:0] userIdx_d;
  logic [IW-1:0] engIdx_q;
  logic [IW-1:0] engIdx_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic ovfl_q;
  logic ovfl_d;
  wire full = (count_q == FULL_CNT);
  wire empty = (count_q == '0);
  wire userOk = userAdv && !clear && (isTx ? !full : !empty);
  wire engOk = engAdv && !clear && (isTx ? !empty : !full);
  wire fill = isTx ? userOk : engOk;
  wire drain = isTx ? engOk : userOk;

  // Slot advance with wrap
  function automatic logic [IW-1:0] nextIdx(input logic [IW-1:0] i);
    nextIdx = (i == LAST_IDX) ? '0 : i + 1'b1;
  endfunction : nextIdx

  assign ovflEvent = engAdv && !clear && !isTx && full;
  assign engDone = engOk;
  assign userIdx_d = clear ? '0 : (userOk ? nextIdx(userIdx_q) : userIdx_q);
  assign engIdx_d = clear ? '0 : (engOk ? nextIdx(engIdx_q) : engIdx_q);
  assign count_d = clear ? '0 :
                   (fill && !drain) ? count_q + 1'b1 :
                   (drain && !fill) ? count_q - 1'b1 : count_q;
  // Set wins over ovflClr in the same cycle, but clear wins over the set
  assign ovfl_d = ovflEvent || (ovfl_q && !ovflClr && !clear);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      userIdx_q <= '0;
      engIdx_q <= '0;
      count_q <= '0;
      ovfl_q <= 1'b0;
    end
    else
    begin
      userIdx_q <= userIdx_d;
      engIdx_q <= engIdx_d;
      count_q <= count_d;
      ovfl_q <= ovfl_d;
    end
  end

  assign userIdx = userIdx_q;
  assign engIdx = engIdx_q;
  assign count = count_q;
  assign overflow = ovfl_q;
endmodule : cfs_fifo_ptr

// File: tb/cfs_engine_model.sv
// Protocol engine model driving per-FIFO advance strobes
`timescale 1ns/100ps
module cfs_engine_model (
  input wire logic clk,
  output logic [15:0] engAdv
);
  initial engAdv = 16'h0000;

  // One strobe per message, gap cycles set the engine pace
  task automatic send(input int fifo, input int num, input int gap);
    repeat (num)
    begin
      engAdv <= 16'h0001 << fifo;
      @(posedge clk);
      engAdv <= 16'h0000;
      repeat (gap + 1) @(posedge clk);
    end
  endtask : send
endmodule : cfs_engine_model

// File: tb/test_can_fifo_status_pointers.sv
// Self-checking bench for the FIFO status and pointer block
`timescale 1ns/100ps
`include "cfs_consts.svh"
module test_can_fifo_status_pointers;
  localparam int DEPTH = 8;
  localparam int MSG = 16;
  localparam logic [31:0] BASE = 32'h0000_4000;
  localparam logic [1:0] OK = `CFS_RESP_OKAY;
  localparam logic [1:0] ERR = `CFS_RESP_SLVERR;
  logic clk, rst_n, irq;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] engAdv;
  int errorCnt, compares;

  cfs_engine_model eng (.clk(clk), .engAdv(engAdv));

  cfs_top #(.DEPTH(DEPTH), .MSG_BYTES(MSG), .BASE_ADDR(BASE)) dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .engAdv(engAdv), .irq(irq)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [11:0] fa(input logic [3:0] n, input logic [1:0] f);
    return {`CFS_FIFO_PAGE, n, f, 2'b00};
  endfunction : fa

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w)
    begin
      @(posedge clk);
      if (aw && awready === 1'b1)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
  endtask : rd

  task automatic t_reset;
    rd(`CFS_OFF_CTRL, 32'h0080_0000, OK);
    rd(fa(0, `CFS_FLD_CI), 32'h0000_0000, OK);
    rd(fa(0, `CFS_FLD_FLAG), 32'h0000_0000, OK);
    eng.send(0, 2, 0);
    rd(fa(0, `CFS_FLD_CI), 32'h0000_0000, OK);
    rd(12'h010, 32'h0000_0000, ERR);
    wr(12'h014, 32'hffff_ffff, ERR);
    wr(fa(0, `CFS_FLD_CI), 32'h0000_001f, OK);
    rd(fa(0, `CFS_FLD_CI), 32'h0000_0000, OK);
    wr(fa(1, `CFS_FLD_FCTL), 32'h0000_0080, OK);
    wr(`CFS_OFF_CTRL, 32'h0000_0000, OK);
    $display("Test reset done");
  endtask : t_reset

  // User address is only read outside configuration mode
  task automatic t_tx;
    rd(fa(1, `CFS_FLD_FLAG), 32'h0000_0300, OK);
    rd(fa(1, `CFS_FLD_UA), BASE + 32'(DEPTH * MSG), OK);
    repeat (4) wr(`CFS_OFF_ADV, 32'h0000_0002, OK);
    rd(fa(1, `CFS_FLD_FLAG), 32'h0000_0200, OK);
    wr(`CFS_OFF_ADV, 32'h0000_0002, OK);
    rd(fa(1, `CFS_FLD_FLAG), 32'h0000_0000, OK);
    rd(fa(1, `CFS_FLD_UA), BASE + 32'((DEPTH + 5) * MSG), OK);
    rd(fa(1, `CFS_FLD_CI), 32'h0000_0000, OK);
    eng.send(1, 5, 1);
    rd(fa(1, `CFS_FLD_CI), 32'h0000_0005, OK);
    rd(fa(1, `CFS_FLD_FLAG), 32'h0000_0300, OK);
    eng.send(1, 1, 0);
    rd(fa(1, `CFS_FLD_CI), 32'h0000_0005, OK);
    $display("Test transmit done");
  endtask : t_tx

  task automatic t_rx;
    eng.send(0, 3, 0);
    rd(fa(0, `CFS_FLD_FLAG), 32'h0000_0001, OK);
    rd(fa(0, `CFS_FLD_CI), 32'h0000_0003, OK);
    eng.send(0, 1, 2);
    rd(fa(0, `CFS_FLD_FLAG), 32'h0000_0003, OK);
    eng.send(0, 4, 0);
    rd(fa(0, `CFS_FLD_FLAG), 32'h0000_0007, OK);
    rd(fa(0, `CFS_FLD_CI), 32'h0000_0000, OK);
    eng.send(0, 1, 0);
    rd(fa(0, `CFS_FLD_FLAG), 32'h0000_000f, OK);
    rd(fa(0, `CFS_FLD_CI), 32'h0000_0000, OK);
    wr(`CFS_OFF_ADV, 32'h0000_0001, OK);
    rd(fa(0, `CFS_FLD_UA), BASE + 32'(MSG), OK);
    rd(fa(0, `CFS_FLD_FLAG), 32'h0000_000b, OK);
    wr(fa(0, `CFS_FLD_FLAG), 32'h0000_0008, OK);
    rd(fa(0, `CFS_FLD_FLAG), 32'h0000_0003, OK);
    $display("Test receive done");
  endtask : t_rx

  task automatic t_irq;
    rd(`CFS_OFF_STAT, 32'h0000_0003, OK);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`CFS_OFF_MASK, 32'h0000_0002, OK);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`CFS_OFF_STAT, 32'h0000_0002, OK);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    rd(`CFS_OFF_STAT, 32'h0000_0001, OK);
    $display("Test interrupt done");
  endtask : t_irq

  task automatic t_dir;
    wr(fa(2, `CFS_FLD_FCTL), 32'h0000_0080, OK);
    rd(fa(2, `CFS_FLD_FLAG), 32'h0000_0000, OK);
    rd(fa(15, `CFS_FLD_UA), BASE + 32'(15 * DEPTH * MSG), OK);
    $display("Test direction done");
  endtask : t_dir

  task automatic finish_test;
    $display("Counts: %0d compares, %0d errors", compares, errorCnt);
    if (errorCnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_tx;
    t_rx;
    t_irq;
    t_dir;
    finish_test;
  end

  initial
  begin
    #80000;
    errorCnt++;
    finish_test;
  end
endmodule : test_can_fifo_status_pointers
